// ### design/msg_enc_pkg.sv
package msg_enc_pkg;

  // ----------------------------------------------------------------
  // Event sources and their message codes
  // ----------------------------------------------------------------
  localparam int NUM_EV = 22;                  // Event strobes from the protocol engine.
  localparam int PW     = 9;                   // Parameter width of a queued entry.
  localparam logic [3:0] NO_GATE = 4'h8;        // Marks a message that no verbosity bit gates.

  // Message code of each event strobe, by strobe index.
  localparam logic [7:0] EV_CODE [NUM_EV] = '{
    8'h65, 8'h66, 8'h67, 8'h68, 8'h69, 8'h6a, 8'h6b, 8'h6f, 8'h70, 8'h71, 8'h72,
    8'h73, 8'h74, 8'h77, 8'h78, 8'h79, 8'h7a, 8'h7b, 8'h80, 8'h81, 8'h82, 8'h83};

  // Verbosity bit that gates each event, or NO_GATE.
  localparam logic [3:0] EV_GATE [NUM_EV] = '{
    4'h4, NO_GATE, NO_GATE, 4'h4, 4'h5, NO_GATE, 4'h5, 4'h2, 4'h3, NO_GATE, 4'h1,
    NO_GATE, NO_GATE, NO_GATE, NO_GATE, NO_GATE, NO_GATE, NO_GATE, NO_GATE, NO_GATE,
    NO_GATE, NO_GATE};

  // Strobe indices (for the users of EVT).
  localparam int EV_SEND_SUCCESS    = 0;
  localparam int EV_SEND_TIMEOUT    = 1;
  localparam int EV_ENQUIRY_TIMEOUT = 2;
  localparam int EV_SEND_BEGUN      = 3;
  localparam int EV_UNRECOGNISED    = 4;
  localparam int EV_CMD_OVERFLOW    = 5;
  localparam int EV_LINE_IDLE       = 6;
  localparam int EV_FOREIGN_TOKEN   = 7;
  localparam int EV_OWN_TOKEN       = 8;
  localparam int EV_TOKEN_TIMEOUT   = 9;
  localparam int EV_ENQUIRY_SENT    = 10;
  localparam int EV_SEND_FAULT      = 11;
  localparam int EV_RECEIVE_FAULT   = 12;
  localparam int EV_TOPO_CHANGING   = 13;
  localparam int EV_TOPO_SETTLED    = 14;
  localparam int EV_RECON_ORIGIN    = 15;
  localparam int EV_RECON_SEEN      = 16;
  localparam int EV_RECON_PEER_VER  = 17;
  localparam int EV_SEND_CANCELLED  = 18;
  localparam int EV_MAP_DONE        = 19;
  localparam int EV_TOKEN_HANDED_ON = 20;
  localparam int EV_RECON_INITIATOR = 21;

  // Codes raised by the block itself.
  localparam logic [7:0] NODE_STATE_CODE      = 8'h75;
  localparam logic [7:0] NEIGHBOUR_ID_CODE    = 8'h76;
  localparam logic [7:0] HOST_QUEUE_DROP_CODE = 8'h7c;
  localparam logic [7:0] HOST_QUEUE_FAIL_CODE = 8'h7d;
  localparam logic [7:0] NODE_LIST_DONE_CODE  = 8'h7e;
  localparam logic [7:0] NODE_LIST_ENTRY_CODE = 8'h7f;
  localparam logic [7:0] EMPTY_CODE           = 8'h00;
  localparam logic [8:0] ZERO_PARAM           = 9'h000;

  // ----------------------------------------------------------------
  // Node list layout and walk limits
  // ----------------------------------------------------------------
  localparam int          NODE_BITS     = 8;     // Node identifier width.
  localparam int          STATE_BITS    = 5;     // Node state field width.
  localparam logic [3:0]  GROUPS_PER_REQ = 4'h8; // Groups per node-list request.
  localparam logic [7:0]  LAST_NODE     = 8'hff;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_EV-1:0]         strobe;         // One-cycle event pulses.
    logic [NUM_EV-1:0][PW-1:0] param;          // Parameter beside each pulse.
  } event_in_t;

  typedef struct packed {
    logic [7:0]    code;                       // Message code.
    logic [PW-1:0] param;                      // Message parameter.
  } msg_t;

  typedef struct packed {
    logic                  wr;                 // Write strobe.
    logic [NODE_BITS-1:0]  id;                 // Node written.
    logic [STATE_BITS-1:0] state;              // Real, emulated, receive, real-adjacency.
    logic [PW-1:0]         next_id;            // Upper neighbour.
  } node_wr_t;

  typedef enum {WALK_IDLE, WALK_SCAN, WALK_NID, WALK_STATE, WALK_NEXT, WALK_DONE} walk_t;

endpackage : msg_enc_pkg

// ### design/msg_encoder.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - enquiry timeout queues 67, parameter zero, error.
// - packet send start queues 68, verbosity bit 4.
// - unrecognised frame queues 69 with frame id.
// - command queue overflow queues error 6A.
// - line activity timeout queues 6B, bit 5.
// - foreign token 6F with destination; own 70.
// - token timeout queues 71 with culprit id.
// - enquiry sent queues 72, verbosity bit 1.
// - send fault 73, receive fault 74, zero.
// - node state 75 only for present nodes.
// - neighbour id 76 follows; eight groups max.
// - topology changing queues 77; settled queues 78.
// - recon origin 79 carries sender id or zero.
// - any reconfiguration burst queues 7A.
// - peer version 7B carries version low byte.
// - internal queue drop reports error 7C.
// - host queue write failure reports error 7D.
// - list end 7E: zero, else next start id.
// - list entry 7F names the following node.
// - cancel 80, map 81, handed 82, initiator 83.
// - reading an empty queue returns code 00.
// - send success 65, send timeout 66 zero.
module msg_encoder #(
  parameter int DEPTH       = 16,              // Host message queue entries.
  parameter bit NODE_LIST_EN = 1'b1            // Node list walk built in.
) (
  input  wire logic                 MCLK,
  input  wire logic                 RST_N,
  input  wire msg_enc_pkg::event_in_t EVT,
  input  wire logic [7:0]           VERBOSITY_LEVEL,
  input  wire msg_enc_pkg::node_wr_t NODE_WR,
  input  wire logic                 NL_REQ,
  input  wire logic [7:0]           NL_START,
  output logic                      NL_BUSY,
  input  wire logic                 HOST_RD,
  output msg_enc_pkg::msg_t         RD_MSG,
  output logic                      QUEUE_EMPTY
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two, at least 2");
  end

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;                              // First stage, read only by the second.
  logic rst_n;                                 // Released reset for the whole block.

  // Assert asynchronously, release on the second clock edge.
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Event capture
  // ----------------------------------------------------------------
  logic [msg_enc_pkg::NUM_EV-1:0]         ev_en;     // Event passes its verbosity gate.
  logic [msg_enc_pkg::NUM_EV-1:0]         pend;      // Event waiting for the host queue.
  logic [msg_enc_pkg::NUM_EV-1:0]         next_pend;
  logic [msg_enc_pkg::NUM_EV-1:0][8:0]    pparam;    // Parameter held with each event.
  logic [msg_enc_pkg::NUM_EV-1:0][8:0]    next_pparam;
  logic [msg_enc_pkg::NUM_EV-1:0]         grant_ev;  // One-hot grant from the arbiter.
  logic                                   grant_drop; // Drop report takes the slot.
  logic                                   drop_flag; // Internal queue dropped a message.
  logic                                   next_drop_flag;
  logic                                   fail_flag; // Host queue refused a write.
  logic                                   next_fail_flag;

  // Each event passes its verbosity gate; ungated ones always pass.
  for (genvar i = 0; i < msg_enc_pkg::NUM_EV; i++) begin : g_gate
    assign ev_en[i] = (msg_enc_pkg::EV_GATE[i] == msg_enc_pkg::NO_GATE) ? 1'b1 :
                      VERBOSITY_LEVEL[msg_enc_pkg::EV_GATE[i][2:0]];
  end

  // One pending slot per event; a second arrival while the first
  // still waits is the drop that 7C reports.
  always_comb begin
    next_pend      = pend & ~grant_ev;
    next_pparam    = pparam;
    next_drop_flag = drop_flag & ~grant_drop;
    for (int i = 0; i < msg_enc_pkg::NUM_EV; i++) begin
      if (EVT.strobe[i] && ev_en[i]) begin
        if (next_pend[i]) begin
          next_drop_flag = 1'b1;
        end else begin
          next_pend[i]   = 1'b1;
          next_pparam[i] = EVT.param[i];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Node table and list walk
  // ----------------------------------------------------------------
  logic [msg_enc_pkg::STATE_BITS-1:0] node_state [256]; // State of each node.
  logic [8:0]                         node_next  [256]; // Upper neighbour of each node.
  msg_enc_pkg::walk_t                 walk, next_walk;
  logic [7:0]                         cur, next_cur;    // Node under inspection.
  logic [3:0]                         groups, next_groups;
  logic [8:0]                         done_param, next_done_param;
  logic                               cur_present;
  logic                               walk_req;         // Walker wants a queue slot.
  logic                               grant_walk;
  msg_enc_pkg::msg_t                  walk_msg;

  // Written by the protocol engine; data needs no reset.
  always_ff @(posedge MCLK) begin
    if (NODE_WR.wr) begin
      node_state[NODE_WR.id] <= NODE_WR.state;
      node_next[NODE_WR.id]  <= NODE_WR.next_id;
    end
  end

  // Present is real, emulated, or real by adjacency count.
  assign cur_present = (node_state[cur][1:0] != 2'b00) ||
                       (node_state[cur][4:3] != 2'b00);

  // The message the walker offers in its current state.
  always_comb begin
    walk_req = 1'b1;
    walk_msg = '{code: msg_enc_pkg::EMPTY_CODE, param: msg_enc_pkg::ZERO_PARAM};
    unique case (walk)
      msg_enc_pkg::WALK_NID: begin
        walk_msg = '{code: msg_enc_pkg::NODE_LIST_ENTRY_CODE, param: {1'b0, cur}};
      end
      msg_enc_pkg::WALK_STATE: begin
        walk_msg = '{code: msg_enc_pkg::NODE_STATE_CODE,
                     param: {4'h0, node_state[cur]}};
      end
      msg_enc_pkg::WALK_NEXT: begin
        walk_msg = '{code: msg_enc_pkg::NEIGHBOUR_ID_CODE, param: node_next[cur]};
      end
      msg_enc_pkg::WALK_DONE: begin
        walk_msg = '{code: msg_enc_pkg::NODE_LIST_DONE_CODE, param: done_param};
      end
      default: begin
        walk_req = 1'b0;                       // Idle and scan offer nothing.
      end
    endcase
  end

  // Walk state: skip absent nodes, then entry, state, neighbour, and stop
  // after eight groups or at the last identifier.
  always_comb begin
    next_walk       = walk;
    next_cur        = cur;
    next_groups     = groups;
    next_done_param = done_param;
    unique case (walk)
      msg_enc_pkg::WALK_IDLE: begin
        if (NL_REQ && NODE_LIST_EN) begin
          next_walk   = msg_enc_pkg::WALK_SCAN;
          next_cur    = NL_START;
          next_groups = 4'h0;
        end
      end
      msg_enc_pkg::WALK_SCAN: begin
        if (cur_present) begin
          next_walk = msg_enc_pkg::WALK_NID;
        end else if (cur == msg_enc_pkg::LAST_NODE) begin
          next_walk       = msg_enc_pkg::WALK_DONE;
          next_done_param = msg_enc_pkg::ZERO_PARAM;
        end else begin
          next_cur = cur + 8'h01;
        end
      end
      msg_enc_pkg::WALK_NID: begin
        if (grant_walk) begin
          next_walk = msg_enc_pkg::WALK_STATE;
        end
      end
      msg_enc_pkg::WALK_STATE: begin
        if (grant_walk) begin
          next_walk = msg_enc_pkg::WALK_NEXT;  // Neighbour follows at once.
        end
      end
      msg_enc_pkg::WALK_NEXT: begin
        if (grant_walk) begin
          next_groups = groups + 4'h1;
          if (cur == msg_enc_pkg::LAST_NODE) begin
            next_walk       = msg_enc_pkg::WALK_DONE;
            next_done_param = msg_enc_pkg::ZERO_PARAM;
          end else if (groups + 4'h1 == msg_enc_pkg::GROUPS_PER_REQ) begin
            next_walk       = msg_enc_pkg::WALK_DONE;
            next_done_param = {1'b0, cur + 8'h01};
          end else begin
            next_walk = msg_enc_pkg::WALK_SCAN;
            next_cur  = cur + 8'h01;
          end
        end
      end
      msg_enc_pkg::WALK_DONE: begin
        if (grant_walk) begin
          next_walk = msg_enc_pkg::WALK_IDLE;
        end
      end
    endcase
  end

  assign NL_BUSY = (walk != msg_enc_pkg::WALK_IDLE);

  // ----------------------------------------------------------------
  // Arbitration into the host queue
  // ----------------------------------------------------------------
  logic              fifo_full;
  logic              fifo_wr;
  logic              grant_fail;
  logic              ev_any;
  msg_enc_pkg::msg_t wr_msg;
  // Nothing enters a full queue.

  // Order: write-failure report, drop report, events by index, then the
  // walker. Events meeting a full queue wait and raise 7D.
  always_comb begin
    grant_ev   = '0;
    grant_drop = 1'b0;
    grant_fail = 1'b0;
    grant_walk = 1'b0;
    ev_any     = 1'b0;
    fifo_wr    = 1'b0;
    wr_msg     = '{code: msg_enc_pkg::EMPTY_CODE, param: msg_enc_pkg::ZERO_PARAM};
    if (!fifo_full) begin
      if (fail_flag) begin
        grant_fail = 1'b1;
        fifo_wr    = 1'b1;
        wr_msg     = '{code: msg_enc_pkg::HOST_QUEUE_FAIL_CODE,
                       param: msg_enc_pkg::ZERO_PARAM};
      end else if (drop_flag) begin
        grant_drop = 1'b1;
        fifo_wr    = 1'b1;
        wr_msg     = '{code: msg_enc_pkg::HOST_QUEUE_DROP_CODE,
                       param: msg_enc_pkg::ZERO_PARAM};
      end else begin
        for (int i = 0; i < msg_enc_pkg::NUM_EV; i++) begin
          if (pend[i] && !ev_any) begin
            ev_any      = 1'b1;
            grant_ev[i] = 1'b1;
            fifo_wr     = 1'b1;
            // Code per event
            wr_msg = '{code: msg_enc_pkg::EV_CODE[i], param: pparam[i]};
          end
        end
        if (!ev_any && walk_req) begin
          grant_walk = 1'b1;
          fifo_wr    = 1'b1;
          wr_msg     = walk_msg;
        end
      end
    end
  end

  // Events pending at a full queue raise a sticky report;
  // a new failure wins over the clear of its own report.
  always_comb begin
    next_fail_flag = fail_flag & ~grant_fail;
    if (fifo_full && pend != '0) begin
      next_fail_flag = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Host message queue
  // ----------------------------------------------------------------
  msg_enc_pkg::msg_t mem [DEPTH];              // Queue storage, oldest at rptr.
  logic [AW:0]       wptr, next_wptr;
  logic [AW:0]       rptr, next_rptr;
  msg_enc_pkg::msg_t next_rd_msg;
  logic              fifo_empty;

  assign fifo_empty  = (wptr == rptr);
  assign fifo_full   = (wptr[AW-1:0] == rptr[AW-1:0]) && (wptr[AW] != rptr[AW]);
  assign QUEUE_EMPTY = fifo_empty;

  // Storage is written without reset; pointers decide what is valid.
  always_ff @(posedge MCLK) begin
    if (fifo_wr) begin
      mem[wptr[AW-1:0]] <= wr_msg;
    end
  end

  // A read returns and removes the oldest entry, or code 00 when empty.
  always_comb begin
    next_wptr   = wptr + {{AW{1'b0}}, fifo_wr};
    next_rptr   = rptr;
    next_rd_msg = RD_MSG;
    if (HOST_RD) begin
      if (fifo_empty) begin
        next_rd_msg = '{code: msg_enc_pkg::EMPTY_CODE,
                        param: msg_enc_pkg::ZERO_PARAM};
      end else begin
        next_rd_msg = mem[rptr[AW-1:0]];
        next_rptr   = rptr + {{AW{1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      pend       <= '0;
      pparam     <= '0;
      drop_flag  <= 1'b0;
      fail_flag  <= 1'b0;
      walk       <= msg_enc_pkg::WALK_IDLE;
      cur        <= 8'h00;
      groups     <= 4'h0;
      done_param <= 9'h000;
      wptr       <= '0;
      rptr       <= '0;
      RD_MSG     <= '0;
    end else begin
      pend       <= next_pend;
      pparam     <= next_pparam;
      drop_flag  <= next_drop_flag;
      fail_flag  <= next_fail_flag;
      walk       <= next_walk;
      cur        <= next_cur;
      groups     <= next_groups;
      done_param <= next_done_param;
      wptr       <= next_wptr;
      rptr       <= next_rptr;
      RD_MSG     <= next_rd_msg;
    end
  end

endmodule : msg_encoder

`default_nettype wire

// ### bench/msg_encoder_properties.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Port checks of the message encoder
// ------------------------------------------------------------
module msg_encoder_properties #(
  parameter bit NODE_LIST_EN = 1'b1            // Node list walk built in.
) (
  input wire logic                   MCLK,
  input wire logic                   RST_N,
  input wire msg_enc_pkg::event_in_t EVT,
  input wire logic [7:0]             VERBOSITY_LEVEL,
  input wire msg_enc_pkg::node_wr_t  NODE_WR,
  input wire logic                   NL_REQ,
  input wire logic [7:0]             NL_START,
  input wire logic                   NL_BUSY,
  input wire logic                   HOST_RD,
  input wire msg_enc_pkg::msg_t      RD_MSG,
  input wire logic                   QUEUE_EMPTY
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // Empty queue, nothing under way.
  sequence quiet_s;
    QUEUE_EMPTY && !NL_BUSY && !NL_REQ && !HOST_RD;
  endsequence
  // One strobe alone after a quiet cycle.
  sequence lone_s(int idx);
    quiet_s ##0 (EVT.strobe == (22'h1 << idx) && $past(QUEUE_EMPTY)
      && $past(EVT.strobe) == '0 && !$past(NL_BUSY));
  endsequence
  // A lone ungated event lands two cycles on.
  property lands_p(int idx);
    lone_s(idx) ##1 !HOST_RD |=> !QUEUE_EMPTY;
  endproperty
  // A lone event with its gate shut has not landed two cycles on.
  property gated_p(int idx, int b);
    (lone_s(idx) ##0 !VERBOSITY_LEVEL[b]) ##1 (!HOST_RD && EVT.strobe == '0 && !NL_BUSY)
      |=> QUEUE_EMPTY;
  endproperty
  empty_read_a: assert property (HOST_RD && QUEUE_EMPTY |=> RD_MSG == 17'h00000)
    else $error("empty read not zero");
  full_read_a: assert property (HOST_RD && !QUEUE_EMPTY |=> RD_MSG.code != 8'h00)
    else $error("filled read gave zero");
  read_hold_a: assert property (!HOST_RD |=> $stable(RD_MSG))
    else $error("read data moved");
  empty_rise_a: assert property ($rose(QUEUE_EMPTY) |-> $past(HOST_RD))
    else $error("empty without read");
  walk_start_a: assert property (NODE_LIST_EN && NL_REQ && !NL_BUSY |=> NL_BUSY [*2])
    else $error("walk not started");
  walk_cause_a: assert property (!NL_BUSY && !NL_REQ |=> !NL_BUSY)
    else $error("walk unasked");
  fault_lands_a: assert property (lands_p(11))
    else $error("73 not queued");
  settle_lands_a: assert property (lands_p(14))
    else $error("78 not queued");
  map_lands_a: assert property (lands_p(19))
    else $error("81 not queued");
  begun_gate_a: assert property (gated_p(3, 4))
    else $error("68 passed gate");
  frame_gate_a: assert property (gated_p(4, 5))
    else $error("69 passed gate");
  token_gate_a: assert property (gated_p(7, 2))
    else $error("6f passed gate");
  enquiry_gate_a: assert property (gated_p(10, 1))
    else $error("72 passed gate");
endmodule : msg_encoder_properties

bind msg_encoder msg_encoder_properties #(.NODE_LIST_EN(NODE_LIST_EN)) i_props (
  .MCLK(MCLK), .RST_N(RST_N), .EVT(EVT), .VERBOSITY_LEVEL(VERBOSITY_LEVEL),
  .NODE_WR(NODE_WR), .NL_REQ(NL_REQ), .NL_START(NL_START), .NL_BUSY(NL_BUSY),
  .HOST_RD(HOST_RD), .RD_MSG(RD_MSG), .QUEUE_EMPTY(QUEUE_EMPTY));
`default_nettype wire

// ### bench/host_reader.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Host model: one queue read per cycle of request
// ------------------------------------------------------------
module host_reader (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              rd_req,      // Bench asks for a read.
  input  wire msg_enc_pkg::msg_t rd_msg,
  output logic                   host_rd,
  output msg_enc_pkg::msg_t      got,         // Last entry read.
  output logic                   got_valid,   // Pulses when got is fresh.
  output logic [7:0]             next_start,  // Start id for the next list request.
  output logic                   settled      // List contents may be trusted.
);
  logic rd_d;                                  // Read taken last edge.
  // Data is taken one edge after the read was accepted.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      {host_rd, rd_d, got_valid, settled, next_start, got} <= '0;
    end else begin
      host_rd   <= rd_req;
      rd_d      <= host_rd;
      got_valid <= rd_d;
      if (rd_d) begin
        got <= rd_msg;
      end
      if (rd_d && rd_msg.code == msg_enc_pkg::NODE_LIST_DONE_CODE) begin
        next_start <= rd_msg.param[7:0];
      end
      // Lists are trusted only after 78.
      if (rd_d && rd_msg.code == 8'h78) begin
        settled <= 1'b1;
      end else if (rd_d && rd_msg.code == 8'h77) begin
        settled <= 1'b0;
      end
    end
  end
endmodule : host_reader
`default_nettype wire

// ### bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  // ------------------------------------------------------------
  // Stimulus, observation and expectations
  // ------------------------------------------------------------
  logic                   mclk = 1'b0;         // 40 MHz clock.
  logic                   rst_n = 1'b0;        // Reset.
  msg_enc_pkg::event_in_t evt = '0;            // Events.
  logic [7:0]             lvl = 8'h00;         // Verbosity.
  msg_enc_pkg::node_wr_t  node_wr = '0;        // Table writes.
  logic                   nl_req = 1'b0;       // List request.
  logic [7:0]             nl_start = 8'h00;    // List start.
  logic                   rd_req = 1'b0;       // Read request.
  logic                   nl_busy;
  logic                   host_rd;
  logic                   queue_empty;
  logic                   got_valid;
  logic                   settled;
  logic [7:0]             next_start;
  msg_enc_pkg::msg_t      rd_msg;
  msg_enc_pkg::msg_t      got;
  msg_enc_pkg::msg_t      exp_q[$];            // Expected entries.
  logic [4:0]             st[256];             // Node states.
  logic [8:0]             nx[256];             // Neighbours.
  logic [8:0]             nxt;                 // Expected restart id.
  logic [7:0]             s;                   // Walk start id.
  int                     seed = 32'h6540;
  int                     mismatches = 0;
  int                     checked = 0;
  int                     n;
  int                     i;

  always #12.5 mclk = ~mclk;

  msg_encoder #(.DEPTH(16), .NODE_LIST_EN(1'b1)) i_msg_encoder (
    .MCLK(mclk), .RST_N(rst_n), .EVT(evt), .VERBOSITY_LEVEL(lvl), .NODE_WR(node_wr),
    .NL_REQ(nl_req), .NL_START(nl_start), .NL_BUSY(nl_busy), .HOST_RD(host_rd),
    .RD_MSG(rd_msg), .QUEUE_EMPTY(queue_empty));
  host_reader i_host_reader (
    .mclk(mclk), .rst_n(rst_n), .rd_req(rd_req), .rd_msg(rd_msg), .host_rd(host_rd),
    .got(got), .got_valid(got_valid), .next_start(next_start), .settled(settled));

  // Compares and counts; an unknown never matches.
  task chk(input logic [16:0] g, input logic [16:0] w);
    checked++;
    if (g !== w) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, w);
      mismatches++;
    end
  endtask : chk

  task stop_test;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // Each entry read is matched in order; empty reads are skipped.
  always @(posedge mclk) begin
    if (got_valid === 1'b1 && got.code !== 8'h00) begin
      if (exp_q.size() == 0) begin
        chk(got, 17'h1ffff);
      end else begin
        chk(got, exp_q.pop_front());
      end
    end
  end

  // Gated events need their verbosity bit.
  function automatic bit gate_open(input int k);
    return msg_enc_pkg::EV_GATE[k] == msg_enc_pkg::NO_GATE || lvl[msg_enc_pkg::EV_GATE[k][2:0]];
  endfunction : gate_open

  // Parameter bits each event carries.
  function automatic logic [8:0] pmask(input int k);
    case (k)
      4, 7, 8, 15, 17: return 9'h0ff;
      9, 21:           return 9'h1ff;
      default:         return 9'h000;
    endcase
  endfunction : pmask

  task ev(input int k, input logic [8:0] p, input bit push, input bit gap);
    @(posedge mclk);
    evt.strobe   <= 22'h1 << k;
    evt.param[k] <= p;
    if (push && gate_open(k)) begin
      exp_q.push_back({msg_enc_pkg::EV_CODE[k], p});
    end
    if (gap) begin
      @(posedge mclk);
      evt.strobe <= '0;
    end
  endtask : ev

  // Reads until all expected came back; the queue must then be empty.
  task drain;
    @(posedge mclk) rd_req <= 1'b1;
    for (n = 0; n < 3000 && exp_q.size() != 0; n++) @(posedge mclk);
    rd_req <= 1'b0;
    repeat (4) @(posedge mclk);
    if (n == 3000) begin
      mismatches++;
      stop_test();
    end
    chk({16'h0, queue_empty}, 17'h1);
  endtask : drain

  task rst;
    rst_n <= 1'b0;
    repeat (5) @(posedge mclk);
    chk({15'h0, queue_empty, nl_busy}, 17'h2);
    chk(rd_msg, 17'h0);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask : rst

  // Expected stream of one walk.
  task automatic walk_exp(input int s0, output logic [8:0] nx_o);
    int g;
    g = 0;
    nx_o = 9'h000;
    for (int id = s0; id < 256 && g < 8; id++) begin
      if (st[id][1:0] != 2'h0 || st[id][4:3] != 2'h0) begin
        exp_q.push_back({msg_enc_pkg::NODE_LIST_ENTRY_CODE, 9'(id)});
        exp_q.push_back({msg_enc_pkg::NODE_STATE_CODE, 9'(st[id])});
        exp_q.push_back({msg_enc_pkg::NEIGHBOUR_ID_CODE, nx[id]});
        g++;
        if (g == 8 && id != 255) nx_o = 9'(id + 1);
      end
    end
    exp_q.push_back({msg_enc_pkg::NODE_LIST_DONE_CODE, nx_o});
  endtask : walk_exp

  initial begin
    rst();
    // Every code at open and shut gates, then random bursts.
    for (int r = 0; r < 10; r++) begin
      @(posedge mclk) lvl <= (r < 2) ? 8'hff : (r < 4) ? 8'h00 : 8'($random(seed));
      for (int k = 0; k < 11; k++) begin
        i = (r < 4) ? k + 11 * (r % 2) : {$random(seed)} % 22;
        ev(i, 9'($random(seed)) & pmask(i), 1'b1, 1'($random(seed)));
      end
      @(posedge mclk) evt.strobe <= '0;
      drain();
    end
    // Gated events with every gate shut.
    @(posedge mclk) lvl <= 8'h00;
    for (int k = 0; k < 22; k++) begin
      if (msg_enc_pkg::EV_GATE[k] != msg_enc_pkg::NO_GATE) begin
        ev(k, 9'h000, 1'b1, 1'b1);
        @(posedge mclk);
      end
    end
    drain();
    // Twenty with no reads: the last four wait behind a 7D report.
    for (int k = 0; k < 20; k++) ev(11 + k % 11, 9'h000, 1'b1, 1'b0);
    @(posedge mclk) evt.strobe <= '0;
    exp_q.insert(16, {msg_enc_pkg::HOST_QUEUE_FAIL_CODE, 9'h000});
    drain();
    // Settled topology first, then the node list in pieces of eight.
    ev(msg_enc_pkg::EV_TOPO_SETTLED, 9'h000, 1'b1, 1'b0);
    @(posedge mclk) evt.strobe <= '0;
    drain();
    chk({16'h0, settled}, 17'h1);
    for (n = 0; n < 256; n++) begin
      @(posedge mclk);
      st[n] = 1'($random(seed)) ? 5'($random(seed)) : 5'h04;
      nx[n] = 9'($random(seed));
      node_wr <= {1'b1, 8'(n), st[n], nx[n]};
    end
    @(posedge mclk) node_wr.wr <= 1'b0;
    for (int w = 0; w < 40; w++) begin
      s = (w == 0) ? 8'h00 : next_start;
      walk_exp(s, nxt);
      @(posedge mclk) begin
        nl_req   <= 1'b1;
        nl_start <= s;
        rd_req   <= 1'b1;
      end
      // A second request while busy must be ignored.
      for (n = 0; n < 4000 && (n < 3 || nl_busy !== 1'b0); n++) begin
        @(posedge mclk);
        nl_req <= (n == 2 && s < 8'hf0);
      end
      if (n == 4000) begin
        mismatches++;
        stop_test();
      end
      drain();
      if (nxt == 9'h000) break;
    end
    // Mid-run reset drops a pending entry; an empty read gives zero.
    ev(msg_enc_pkg::EV_MAP_DONE, 9'h000, 1'b0, 1'b0);
    @(posedge mclk) evt.strobe <= '0;
    rst();
    @(posedge mclk) rd_req <= 1'b1;
    @(posedge mclk) rd_req <= 1'b0;
    for (n = 0; n < 6 && got_valid !== 1'b1; n++) @(negedge mclk);
    chk(got, 17'h00000);
    stop_test();
  end
endmodule : tb
`default_nettype wire
